// ==== verilog/tx_irq_pkg.sv ====
package tx_irq_pkg;
	// Avalon byte address width; register index is address[9:2]
	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;

	// Register indices, byte address is four times the index
	localparam logic [7:0] IDX_BLOCK_IRQ_EN = 8'h04;
	localparam logic [7:0] IDX_ALARM_CFG = 8'h31;
	localparam logic [7:0] IDX_ALARM_CODE = 8'h32;
	localparam logic [7:0] IDX_LINK_STAT = 8'h34;

	// Block interrupt enable fields
	localparam int BIT_SECOND_EN = 0;
	localparam int BIT_TX_BLOCK_EN = 1;
	localparam int BIT_RX_BLOCK_EN = 7;

	// Alarm message config and status fields
	localparam int BIT_ALARM_BUSY = 0;
	localparam int BIT_ALARM_GO = 1;
	localparam int BIT_ALARM_TXEN = 2;
	localparam int BIT_ALARM_FLAG = 3;
	localparam int BIT_ALARM_IEN = 4;

	// Link message status and interrupt fields
	localparam int BIT_LINK_FLAG = 0;
	localparam int BIT_LINK_IEN = 1;
	localparam int BIT_LINK_BUSY = 2;
	localparam int BIT_LINK_START = 3;

	// Reset values
	localparam logic [7:0] RST_BLOCK_IRQ_EN = 8'h00;
	localparam logic [7:0] RST_ALARM_CFG = 8'h00;
	localparam logic [7:0] RST_ALARM_CODE = 8'h00;
	localparam logic [7:0] RST_LINK_STAT = 8'h00;

	// Alarm message framing
	localparam int ALARM_CODE_BITS = 6;
	localparam int ALARM_WORD_BITS = 16;
	localparam int ALARM_REPEATS = 10;
	localparam logic [7:0] ALARM_FILL = 8'hff;
endpackage

// ==== verilog/alarm_msg_sender.sv ====
`timescale 1ns/1ns
module alarm_msg_sender
	import tx_irq_pkg::*;
#(
	parameter int REPEATS = ALARM_REPEATS
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic start,
	input wire logic [ALARM_CODE_BITS-1:0] code,
	input wire logic slot,
	output logic busy,
	output logic done,
	output logic bitOut
);
	localparam int BIT_W = $clog2(ALARM_WORD_BITS);
	localparam int REP_W = $clog2(REPEATS);
	localparam logic [BIT_W-1:0] LAST_BIT = BIT_W'(ALARM_WORD_BITS - 1);
	localparam logic [REP_W-1:0] LAST_REP = REP_W'(REPEATS - 1);

	// Sender states
	typedef enum logic {IDLE, SEND} send_state_t;

	send_state_t state, next_state;
	// Captured structure, sent MSB first
	logic [ALARM_WORD_BITS-1:0] word, next_word;
	logic [BIT_W-1:0] bitCnt, next_bitCnt;
	logic [REP_W-1:0] repCnt, next_repCnt;
	logic next_busy, next_done, next_bitOut;

	// Next state of the sender
	always_comb begin
		next_state = state;
		next_word = word;
		next_bitCnt = bitCnt;
		next_repCnt = repCnt;
		next_busy = busy;
		next_done = 1'b0;
		next_bitOut = bitOut;
		unique case (state)
			IDLE: begin
				if (start) begin
					next_word = {1'b0, code, 1'b0, ALARM_FILL};
					next_bitCnt = '0;
					next_repCnt = '0;
					next_busy = 1'b1;
					next_state = SEND;
				end
			end
			SEND: begin
				// One bit per line slot
				if (slot) begin
					next_bitOut = word[LAST_BIT - bitCnt];
					if (bitCnt == LAST_BIT) begin
						next_bitCnt = '0;
						if (repCnt == LAST_REP) begin
							next_done = 1'b1;
							next_busy = 1'b0;
							next_state = IDLE;
						end else begin
							next_repCnt = repCnt + 1'b1;
						end
					end else begin
						next_bitCnt = bitCnt + 1'b1;
					end
				end
			end
		endcase
	end

	// Sender registers, frozen while ce is low
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= IDLE;
			word <= '0;
			bitCnt <= '0;
			repCnt <= '0;
			busy <= 1'b0;
			done <= 1'b0;
			bitOut <= 1'b1;
		end else if (ce) begin
			state <= next_state;
			word <= next_word;
			bitCnt <= next_bitCnt;
			repCnt <= next_repCnt;
			busy <= next_busy;
			done <= next_done;
			bitOut <= next_bitOut;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	a_capture_word: assert property (ce && state == IDLE && start |=>
		word == {1'b0, $past(code), 1'b0, ALARM_FILL})
		else $error("captured structure wrong");
	a_ten_repeats: assert property ($rose(done) |->
		$past(repCnt) == LAST_REP && $past(bitCnt) == LAST_BIT && $past(slot))
		else $error("done before last copy");
	c_msg_done: cover property (busy ##1 done);
endmodule

// ==== verilog/tx_section_irq.sv ====
// What this block does
// - Bit 1 at 0x04 enables transmit interrupts
// - Block enable clear suppresses every transmit interrupt
// - Interrupt needs block and source enable
// - Two sources: alarm and link message done
// - Alarm done source enable at 0x31 bit 4
// - Send command with transmit enable (0x31 bit 2) starts full alarm sequence
// - Capture six-bit code into 16-bit structure
// - Send structure ten times then complete
// - Enabled alarm completion drives interrupt low
// - Alarm completion sets 0x31 bit 3
// - Link done source enable at 0x34 bit 1
// - Link completion sets 0x34 bit 0, interrupts if enabled
`timescale 1ns/1ns
module tx_section_irq
	import tx_irq_pkg::*;
#(
	parameter int REPEATS = ALARM_REPEATS
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [DATA_W-1:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [DATA_W-1:0] readdata,
	output logic waitrequest,
	input wire logic alarmBitSlot,
	output logic alarmBit,
	output logic alarmSending,
	input wire logic linkMsgDone,
	input wire logic linkMsgBusy,
	output logic linkMsgStart,
	output logic irq_n
);
	// Register index from the byte address
	logic [7:0] idx;
	// Request present on the bus
	logic req;
	// Edge at which the slave answers
	logic accept;
	// First cycle of a request, when read data is snapped
	logic snap;
	// Write committed to the low byte
	logic wrLow;

	// Stored register bits
	logic [7:0] blkEn, next_blkEn;
	logic alarmIen, next_alarmIen;
	logic alarmTxEn, next_alarmTxEn;
	logic alarmGo, next_alarmGo;
	logic alarmFlag, next_alarmFlag;
	logic [7:0] alarmCode, next_alarmCode;
	logic linkIen, next_linkIen;
	logic linkFlag, next_linkFlag;
	logic next_linkMsgStart;
	// Bus answer and interrupt pin registers
	logic [DATA_W-1:0] next_readdata;
	logic next_waitrequest;
	logic next_irq_n;

	// Sender handshake
	logic alarmStart;
	logic alarmDone;
	// Any enabled source pending
	logic alarmPend;
	logic linkPend;

	// Bus decode
	always_comb begin
		idx = address[ADDR_W-1:2];
		req = read | write;
		accept = req & ~waitrequest;
		snap = req & waitrequest;
		// Writes need the low byte lane
		wrLow = write & accept & byteenable[0];
	end

	always_comb begin
		alarmStart = alarmGo & alarmTxEn & ~alarmSending;
	end

	// Alarm message serializer
	alarm_msg_sender #(
		.REPEATS(REPEATS)
	) u_sender (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.ce(ce),
		.start(alarmStart),
		.code(alarmCode[ALARM_CODE_BITS-1:0]),
		.slot(alarmBitSlot),
		.busy(alarmSending),
		.done(alarmDone),
		.bitOut(alarmBit)
	);

	// Enabled sources, before block gating
	always_comb begin
		alarmPend = alarmFlag & alarmIen;
		linkPend = linkFlag & linkIen;
	end

	// Next values of registers, flags and bus answer
	always_comb begin
		next_blkEn = blkEn;
		next_alarmIen = alarmIen;
		next_alarmTxEn = alarmTxEn;
		next_alarmGo = alarmGo;
		next_alarmFlag = alarmFlag;
		next_alarmCode = alarmCode;
		next_linkIen = linkIen;
		next_linkFlag = linkFlag;
		next_linkMsgStart = linkMsgStart;
		next_readdata = readdata;

		// One-cycle answer: wait high, then low for one cycle
		next_waitrequest = ~snap;

		// Snap read data in the first request cycle
		if (snap && read) begin
			next_readdata = '0;
			unique case (idx)
				IDX_BLOCK_IRQ_EN: next_readdata[7:0] = blkEn;
				// Config: enable, flag, transmit, command, busy
				IDX_ALARM_CFG: begin
					next_readdata[BIT_ALARM_IEN] = alarmIen;
					next_readdata[BIT_ALARM_FLAG] = alarmFlag;
					next_readdata[BIT_ALARM_TXEN] = alarmTxEn;
					next_readdata[BIT_ALARM_GO] = alarmGo;
					next_readdata[BIT_ALARM_BUSY] = alarmSending;
				end
				// Whole code byte reads back
				IDX_ALARM_CODE: next_readdata[7:0] = alarmCode;
				// Link: start, busy, enable, flag
				IDX_LINK_STAT: begin
					next_readdata[BIT_LINK_START] = linkMsgStart;
					next_readdata[BIT_LINK_BUSY] = linkMsgBusy;
					next_readdata[BIT_LINK_IEN] = linkIen;
					next_readdata[BIT_LINK_FLAG] = linkFlag;
				end
				// Unmapped reads return zero
				default: next_readdata = '0;
			endcase
		end

		// read clears the flag it returned
		if (snap && read && idx == IDX_ALARM_CFG) begin
			next_alarmFlag = 1'b0;
		end
		if (snap && read && idx == IDX_LINK_STAT) begin
			next_linkFlag = 1'b0;
		end

		// Register writes at the accept edge
		if (wrLow) begin
			unique case (idx)
				IDX_BLOCK_IRQ_EN: begin
					next_blkEn[BIT_TX_BLOCK_EN] = writedata[BIT_TX_BLOCK_EN];
					next_blkEn[BIT_SECOND_EN] = writedata[BIT_SECOND_EN];
					next_blkEn[BIT_RX_BLOCK_EN] = writedata[BIT_RX_BLOCK_EN];
				end
				IDX_ALARM_CFG: begin
					next_alarmIen = writedata[BIT_ALARM_IEN];
					next_alarmTxEn = writedata[BIT_ALARM_TXEN];
					next_alarmGo = writedata[BIT_ALARM_GO];
				end
				// Full byte stored, low six bits sent
				IDX_ALARM_CODE: next_alarmCode = writedata[7:0];
				IDX_LINK_STAT: begin
					next_linkIen = writedata[BIT_LINK_IEN];
					next_linkMsgStart = writedata[BIT_LINK_START];
				end
				// Unmapped writes are dropped
				default: next_alarmCode = alarmCode;
			endcase
		end

		// Command is consumed when the sender takes it
		if (alarmStart) begin
			next_alarmGo = 1'b0;
		end

		if (alarmDone) begin
			next_alarmFlag = 1'b1;
		end
		if (linkMsgDone) begin
			next_linkFlag = 1'b1;
		end
	end

	// Interrupt pin, active low
	always_comb begin
		next_irq_n = ~(blkEn[BIT_TX_BLOCK_EN] & (alarmPend | linkPend));
	end

	// Register all state, frozen while ce is low
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			// Register reset values
			blkEn <= RST_BLOCK_IRQ_EN;
			alarmIen <= RST_ALARM_CFG[BIT_ALARM_IEN];
			alarmTxEn <= RST_ALARM_CFG[BIT_ALARM_TXEN];
			alarmGo <= RST_ALARM_CFG[BIT_ALARM_GO];
			alarmFlag <= RST_ALARM_CFG[BIT_ALARM_FLAG];
			alarmCode <= RST_ALARM_CODE;
			linkIen <= RST_LINK_STAT[BIT_LINK_IEN];
			linkFlag <= RST_LINK_STAT[BIT_LINK_FLAG];
			linkMsgStart <= RST_LINK_STAT[BIT_LINK_START];
			readdata <= '0;
			waitrequest <= 1'b1;
			irq_n <= 1'b1;
		end else if (ce) begin
			// Advance only while enabled
			blkEn <= next_blkEn;
			alarmIen <= next_alarmIen;
			alarmTxEn <= next_alarmTxEn;
			alarmGo <= next_alarmGo;
			alarmFlag <= next_alarmFlag;
			alarmCode <= next_alarmCode;
			linkIen <= next_linkIen;
			linkFlag <= next_linkFlag;
			linkMsgStart <= next_linkMsgStart;
			readdata <= next_readdata;
			waitrequest <= next_waitrequest;
			irq_n <= next_irq_n;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// Block gate holds pin high
	a_block_gate_off: assert property (ce && !blkEn[BIT_TX_BLOCK_EN] |=> irq_n)
		else $error("interrupt with block disabled");
	a_source_gate_off: assert property (ce && !alarmPend && !linkPend |=> irq_n)
		else $error("interrupt without enabled source");
	a_alarm_irq_low: assert property (ce && blkEn[BIT_TX_BLOCK_EN] && alarmPend
		|=> !irq_n)
		else $error("alarm completion did not interrupt");
	a_link_irq_low: assert property (ce && blkEn[BIT_TX_BLOCK_EN] && linkPend
		|=> !irq_n)
		else $error("link completion did not interrupt");
	a_alarm_flag_set: assert property (ce && alarmDone |=> alarmFlag)
		else $error("alarm flag not set");
	a_link_flag_set: assert property (ce && linkMsgDone |=> linkFlag)
		else $error("link flag not set");
	a_read_clears: assert property (ce && snap && read && idx == IDX_ALARM_CFG
		&& !alarmDone |=> !alarmFlag)
		else $error("read did not clear alarm flag");
	a_block_en_write: assert property (ce && wrLow && idx == IDX_BLOCK_IRQ_EN
		|=> blkEn[BIT_TX_BLOCK_EN] == $past(writedata[BIT_TX_BLOCK_EN]))
		else $error("block enable not written");
	a_src_en_write: assert property (ce && wrLow && idx == IDX_ALARM_CFG
		|=> alarmIen == $past(writedata[BIT_ALARM_IEN]))
		else $error("alarm enable not written");
	a_link_en_write: assert property (ce && wrLow && idx == IDX_LINK_STAT
		|=> linkIen == $past(writedata[BIT_LINK_IEN]))
		else $error("link enable not written");
	a_go_starts: assert property (ce && alarmStart |=> alarmSending && !alarmGo)
		else $error("send command not taken");
	a_one_wait: assert property (ce && snap |=> !waitrequest ##1 waitrequest)
		else $error("bus answer not one cycle");

	// Read of link status clears its flag
	a_link_read_clears: assert property (ce && snap && read && idx == IDX_LINK_STAT
		&& !linkMsgDone |=> !linkFlag)
		else $error("read did not clear link flag");
	// Writes without the low byte lane change nothing
	a_lane_gate: assert property (ce && write && accept && !byteenable[0]
		|=> blkEn == $past(blkEn) && alarmCode == $past(alarmCode))
		else $error("write without byte lane took effect");
	// Read data carries only the low byte
	a_read_upper_zero: assert property (ce && snap && read
		|=> readdata[DATA_W-1:8] == '0)
		else $error("read data upper bits not zero");
	// Busy bit reads the sender state
	a_busy_reads: assert property (ce && snap && read && idx == IDX_ALARM_CFG
		|=> readdata[BIT_ALARM_BUSY] == $past(alarmSending))
		else $error("busy bit read wrong");
	// Code register takes the written byte
	a_code_write: assert property (ce && wrLow && idx == IDX_ALARM_CODE
		|=> alarmCode == $past(writedata[7:0]))
		else $error("code not written");

	c_alarm_irq: cover property (alarmDone ##[1:3] !irq_n);
	c_link_irq: cover property (linkMsgDone ##[1:3] !irq_n);
	c_read_clear: cover property (!irq_n ##1 (snap && read) ##[1:3] irq_n);
	c_send_run: cover property (alarmStart ##[1:1000] alarmDone);
endmodule

// ==== bench/line_side_model.sv ====
`timescale 1ns/1ns
module line_side_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic linkMsgStart,
	output logic alarmBitSlot,
	output logic linkMsgBusy,
	output logic linkMsgDone
);
	logic [1:0] slotCnt; // Slot pacing
	logic startSeen; // Last start level
	logic [2:0] busyCnt; // Cycles left in link message

	// Busy while a link message is in flight
	assign linkMsgBusy = (busyCnt != 3'h0);

	// Slot every third cycle; link message starts on rising start
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			slotCnt <= 2'h0;
			alarmBitSlot <= 1'b0;
			startSeen <= 1'b0;
			busyCnt <= 3'h0;
			linkMsgDone <= 1'b0;
		end else begin
			slotCnt <= (slotCnt == 2'h2) ? 2'h0 : slotCnt + 2'h1;
			alarmBitSlot <= (slotCnt == 2'h2);
			startSeen <= linkMsgStart;
			linkMsgDone <= (busyCnt == 3'h1);
			if (linkMsgStart && !startSeen) begin
				busyCnt <= 3'h6;
			end else if (busyCnt != 3'h0) begin
				busyCnt <= busyCnt - 3'h1;
			end
		end
	end
endmodule

// ==== bench/tb_tx_section_irq.sv ====
`timescale 1ns/1ns
module tb_tx_section_irq;
	import tx_irq_pkg::*;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [ADDR_W-1:0] address = '0;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [DATA_W-1:0] writedata = '0;
	logic [DATA_W-1:0] readdata;
	logic waitrequest, alarmBitSlot, alarmBit, alarmSending;
	logic linkMsgDone, linkMsgBusy, linkMsgStart, irq_n;
	int miscompares = 0;
	int checks_done = 0;
	int cycles = 0;
	int nBits = 0; // Alarm bits captured
	logic [31:0] bits = '0; // Captured alarm bits
	logic slotSeen = 1'b0; // Slot seen while sending
	logic [15:0] word; // Expected structure
	logic ce = 1'b1; // Clock enable, dropped once mid-send
	logic [3:0] byteEn = 4'h1; // Byte lanes of the next write
	int nBase = 0; // Bit count before a send

	always #2 clk_sys = ~clk_sys;

	tx_section_irq #(.REPEATS(2)) tx_section_irq_inst (.clk_sys(clk_sys), .reset_n(reset_n),
		.ce(ce), .address(address), .read(read), .write(write), .writedata(writedata),
		.byteenable(byteEn), .readdata(readdata), .waitrequest(waitrequest),
		.alarmBitSlot(alarmBitSlot), .alarmBit(alarmBit), .alarmSending(alarmSending),
		.linkMsgDone(linkMsgDone), .linkMsgBusy(linkMsgBusy), .linkMsgStart(linkMsgStart),
		.irq_n(irq_n));
	line_side_model line_side_model_inst (.clk_sys(clk_sys), .reset_n(reset_n),
		.linkMsgStart(linkMsgStart), .alarmBitSlot(alarmBitSlot),
		.linkMsgBusy(linkMsgBusy), .linkMsgDone(linkMsgDone));

	// Capture serial bit after each slot taken while sending; cut hangs
	always @(posedge clk_sys) begin
		slotSeen <= alarmBitSlot & alarmSending & ce;
		if (slotSeen) begin
			bits <= {bits[30:0], alarmBit};
			nBits <= nBits + 1;
		end
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// One Avalon transfer; held until waitrequest low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		address <= {idx, 2'b00};
		read <= ~wr;
		write <= wr;
		writedata <= {24'h0, d};
		// Values read right after the edge are those sampled at it
		do begin
			@(posedge clk_sys);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] q;
		bus(1'b0, idx, 8'h00, q);
		chk(q, {24'h0, exp});
	endtask

	// Bounded wait for irq_n (sel 0) or alarmSending (sel 1) to reach lvl
	task automatic waitFor(input int sel, input logic lvl);
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (((sel == 0) ? irq_n : alarmSending) !== lvl && n < 400);
		chk({31'h0, (sel == 0) ? irq_n : alarmSending}, {31'h0, lvl});
		@(posedge clk_sys);
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b0;
		@(posedge clk_sys);
		reset_n <= 1'b1;
		// Reset values and unmapped read
		chk({31'h0, irq_n}, 32'h1);
		wr(8'h3f, 8'hff);
		rd(IDX_BLOCK_IRQ_EN, RST_BLOCK_IRQ_EN);
		rd(IDX_ALARM_CFG, RST_ALARM_CFG);
		rd(IDX_ALARM_CODE, RST_ALARM_CODE);
		rd(IDX_LINK_STAT, RST_LINK_STAT);
		rd(8'h3f, 8'h00);
		wr(IDX_BLOCK_IRQ_EN, 8'h83);
		rd(IDX_BLOCK_IRQ_EN, 8'h83);
		// Write without the low byte lane is ignored
		byteEn <= 4'h0;
		wr(IDX_BLOCK_IRQ_EN, 8'h00);
		byteEn <= 4'h1;
		rd(IDX_BLOCK_IRQ_EN, 8'h83);
		$display("registers done");
		// Enabled alarm message; code changed mid-send must not leak
		wr(IDX_BLOCK_IRQ_EN, 8'h02);
		wr(IDX_ALARM_CODE, 8'h2a);
		wr(IDX_ALARM_CFG, 8'h16);
		wr(IDX_ALARM_CODE, 8'h15);
		waitFor(0, 1'b0);
		word = {1'b0, 6'h2a, 1'b0, 8'hff};
		chk(bits, {word, word});
		chk(nBits, 32'd32);
		rd(IDX_ALARM_CFG, 8'h1c);
		waitFor(0, 1'b1);
		rd(IDX_ALARM_CFG, 8'h14);
		$display("alarm enabled done");
		// Source enable clear keeps pin high; a ce freeze loses no slot
		nBase = nBits;
		wr(IDX_ALARM_CFG, 8'h06);
		waitFor(1, 1'b1);
		ce <= 1'b0;
		repeat (30) @(posedge clk_sys);
		ce <= 1'b1;
		waitFor(1, 1'b0);
		@(negedge clk_sys);
		chk(nBits - nBase, 32'd32);
		repeat (4) @(posedge clk_sys);
		chk({31'h0, irq_n}, 32'h1);
		rd(IDX_ALARM_CFG, 8'h0c);
		$display("alarm masked done");
		// Link message with block disabled, then enabled
		wr(IDX_BLOCK_IRQ_EN, 8'h00);
		wr(IDX_LINK_STAT, 8'h0a);
		@(negedge clk_sys);
		chk({31'h0, linkMsgStart}, 32'h1);
		repeat (14) @(posedge clk_sys);
		chk({31'h0, irq_n}, 32'h1);
		wr(IDX_BLOCK_IRQ_EN, 8'h02);
		waitFor(0, 1'b0);
		rd(IDX_LINK_STAT, 8'h0b);
		waitFor(0, 1'b1);
		wr(IDX_LINK_STAT, 8'h00);
		rd(IDX_LINK_STAT, 8'h00);
		$display("link done");
		end_of_test();
	end
endmodule
